// ### hw/sdf_sensor.sv
// module: sensor end, i2c target that serves pressure and temperature packets
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RL1] acknowledge only the configured address, default 28
// [RL2] read: start, address, read bit, then acknowledge
// [RL3] send bytes while master acks; nack ends
// [RL4] byte one status plus pressure high, two low
// [RL5] pressure-only: master acks one, nacks two, stops
// [RL6] master ack of byte two brings temperature high
// [RL7] byte four: temperature low three, rest undefined
// [RL8] empty start-stop spoils the next transaction
// [RL9] repeated start spoils the next transaction too
// [RL10] master keeps sda low from start through bit
// [RL11] status codes: fresh, command, stale, fault
// [RL12] stale once read, fresh after new result
// [RL13] fetch before first result reports stale
// [RL14] any of four faults gives status 11
// [RL15] fault seen next cycle, reported next fetch
// [RL16] fault stays latched until power-on reset
// [RL17] packet captured at address acknowledge
module sdf_sensor
  import sdf_pkg::*;
#(
  parameter logic [6:0] ADDR = SDF_ADDR_DEFAULT // configured target address
) (
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // measurement engine side
  input  wire logic        meas_done_in,   // one-cycle pulse: new result ready
  input  wire logic [13:0] pressure_in,    // result pressure
  input  wire logic [10:0] temperature_in, // result temperature
  input  wire sdf_fault_t  fault_in,       // live fault sources
  input  wire logic        cmd_mode_in,    // device in command mode
  // status view
  output logic             busy_out,       // in a transaction
  output logic             diag_out,       // fault latched
  output logic             fetched_out,    // pulse: one packet byte sent
  // bus
  sdf_link_if.sensor       link
);
  // ------------------------------------------------------------------
  // pin front end
  // ------------------------------------------------------------------
  logic scl_w, sda_w, scl_rise_w, scl_fall_w, start_w, stop_w;
  sdf_pin_sync u_sync (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .clk_en_in    (clk_en_in),
    .scl_in       (link.scl),
    .sda_in       (link.sda),
    .scl_out      (scl_w),
    .sda_out      (sda_w),
    .scl_rise_out (scl_rise_w),
    .scl_fall_out (scl_fall_w),
    .start_out    (start_w),
    .stop_out     (stop_w)
  );

  // ------------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------------
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_DATA, S_MACK, S_IGNORE} sdf_sen_state_t;
  sdf_sen_state_t state_reg, state_next; // transaction stage
  logic [7:0]  shift_reg;      // address bits shifted in from sda
  logic [2:0]  bit_reg;        // bit counter within byte
  logic [1:0]  byte_reg;       // packet byte index
  logic [31:0] packet_reg;     // frozen packet for this fetch
  logic        pulses_reg;     // any scl pulse since the start
  logic        spoil_reg;      // next transaction must fail
  logic        have_result_reg;// a measurement has completed
  logic        read_reg;       // current result already fetched
  logic        fault_seen_reg; // fault noticed, waits for a cycle end
  logic        diag_reg;       // latched diagnostic
  logic        sda_drv_reg;    // sda pulled low when set
  logic [13:0] press_reg;      // held result
  logic [10:0] temp_reg;

  // ------------------------------------------------------------------
  // status decode
  // ------------------------------------------------------------------
  logic [1:0] status_w;
  logic       addr_hit_w;
  // fault outranks command mode which outranks freshness
  assign status_w = diag_reg ? SDF_ST_DIAG :                    // see [RL14]
                    cmd_mode_in ? SDF_ST_CMD :                  // see [RL11]
                    (!have_result_reg || read_reg) ? SDF_ST_STALE : // see [RL13]
                    SDF_ST_FRESH;                               // see [RL12]
  // address match; a spoiled transaction is never acknowledged
  assign addr_hit_w = (shift_reg[6:0] == ADDR) && (sda_w == SDF_DIR_READ) &&
                      !spoil_reg; // see [RL1] see [RL8]
  logic [31:0] packet_w;
  // byte layout, msb first on the wire
  assign packet_w = {status_w, press_reg,                       // see [RL4]
                     temp_reg, {SDF_TEMP_LO_PAD{1'b0}}};        // see [RL6] see [RL7]

  // ------------------------------------------------------------------
  // transaction sequencer
  // ------------------------------------------------------------------
  logic ack_take_w; // address bit 8 sampled and addressed to us
  assign ack_take_w = (state_reg == S_ADDR) && scl_rise_w && (bit_reg == 3'h7) && addr_hit_w;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:   state_next = state_reg;
      S_ADDR:   begin
        if (scl_rise_w && bit_reg == 3'h7)
          state_next = addr_hit_w ? S_AACK : S_IGNORE; // see [RL2]
      end
      // our ack pulse ends on the second fall
      S_AACK:   if (scl_fall_w && sda_drv_reg) state_next = S_DATA;
      S_DATA:   if (scl_rise_w && bit_reg == 3'h0) state_next = S_MACK;
      S_MACK:   begin
        // master nack ends the packet, ack asks for more
        if (scl_rise_w) state_next = sda_w ? S_IGNORE : S_DATA; // see [RL3]
      end
      S_IGNORE: state_next = state_reg;
    endcase
    if (start_w) state_next = S_ADDR;
    if (stop_w)  state_next = S_IDLE;
  end

  // sequencer registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg   <= S_IDLE;
      shift_reg   <= 8'h00;
      bit_reg     <= 3'h0;
      byte_reg    <= 2'h0;
      packet_reg  <= 32'h0000_0000;
      pulses_reg  <= 1'b0;
      spoil_reg   <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      if (start_w) begin
        // a start inside a live transfer is a repeated start
        if (state_reg != S_IDLE && state_reg != S_ADDR) spoil_reg <= 1'b1; // see [RL9]
        // a second start with a spoil pending and no scl pulse since the first recovers the link
        else if (state_reg == S_ADDR && spoil_reg && pulses_reg) spoil_reg <= 1'b1;
        else if (state_reg == S_ADDR && spoil_reg) spoil_reg <= 1'b0;
        pulses_reg  <= 1'b0;
        bit_reg     <= 3'h0;
        sda_drv_reg <= 1'b0;
      end else if (stop_w) begin
        // start then stop with no scl pulse spoils the next one
        if (state_reg == S_ADDR && !pulses_reg) spoil_reg <= 1'b1; // see [RL8]
        else if (state_reg != S_ADDR && state_reg != S_IDLE) spoil_reg <= spoil_reg;
        sda_drv_reg <= 1'b0;
      end else begin
        if (scl_rise_w) pulses_reg <= 1'b1;
        // the failed transaction consumes the spoil, else retry at next start
        if (state_reg == S_ADDR && scl_rise_w) begin
          shift_reg <= {shift_reg[6:0], sda_w};
          bit_reg   <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) spoil_reg <= 1'b0;
        end
        if (ack_take_w) begin
          packet_reg <= packet_w; // see [RL17]
          byte_reg   <= 2'h0;
        end
        if (scl_fall_w) begin
          unique case (state_reg)
            S_AACK: begin
              sda_drv_reg <= ~sda_drv_reg;
              if (sda_drv_reg) begin
                sda_drv_reg <= ~packet_reg[31];
                bit_reg     <= 3'h1;
              end
            end
            // bit_reg names the bit placed on this fall, 0 after a master ack
            S_DATA: sda_drv_reg <= ~packet_reg[5'd31 - {byte_reg, bit_reg}];
            S_MACK: begin
              // the ack slot belongs to the master
              sda_drv_reg <= 1'b0; // see [RL3]
            end
            default: sda_drv_reg <= 1'b0;
          endcase
          if (state_reg == S_DATA) bit_reg <= bit_reg + 3'h1;
        end
        if (state_reg == S_DATA && scl_rise_w && bit_reg == 3'h0)
          byte_reg <= byte_reg + 2'h1; // byte fully sent
      end
    end
  end

  // ------------------------------------------------------------------
  // result freshness and diagnostic latch
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      have_result_reg <= 1'b0;
      read_reg        <= 1'b0;
      fault_seen_reg  <= 1'b0;
      diag_reg        <= 1'b0;
      press_reg       <= 14'h0000;
      temp_reg        <= 11'h000;
    end else if (clk_en_in) begin
      if (|fault_in) fault_seen_reg <= 1'b1;
      if (meas_done_in) begin
        // only a completed cycle carries the fault to the status
        if (fault_seen_reg || |fault_in) diag_reg <= 1'b1; // see [RL15] see [RL16]
        have_result_reg <= 1'b1;
        press_reg       <= pressure_in;
        temp_reg        <= temperature_in;
        read_reg        <= 1'b0; // new result wins over a fetch this cycle
      end else if (ack_take_w) begin
        read_reg <= 1'b1; // see [RL12]
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign link.sda_oe_n_s = ~sda_drv_reg;
  assign busy_out        = (state_reg != S_IDLE);
  assign diag_out        = diag_reg;
  assign fetched_out     = clk_en_in && state_reg == S_DATA && scl_rise_w && bit_reg == 3'h0;
endmodule : sdf_sensor
`default_nettype wire

// ### hw/sdf_pkg.sv
// package: constants and types shared by both ends of the sensor data fetch link
package sdf_pkg;
  // ------------------------------------------------------------------
  // bus addressing and framing
  // ------------------------------------------------------------------
  localparam logic [6:0] SDF_ADDR_DEFAULT = 7'h28; // factory target address
  localparam int         SDF_ADDR_BITS    = 7;     // address width
  localparam logic       SDF_DIR_READ     = 1'b1;  // read direction bit
  localparam int         SDF_BYTE_BITS    = 8;     // bits per byte
  localparam int         SDF_MAX_BYTES    = 4;     // longest packet
  // ------------------------------------------------------------------
  // packet field layout
  // ------------------------------------------------------------------
  localparam int SDF_PRESS_BITS = 14; // pressure width
  localparam int SDF_TEMP_BITS  = 11; // temperature width
  localparam int SDF_TEMP_HI_LSB = 3; // lowest temperature bit kept in byte 3
  localparam int SDF_TEMP_LO_PAD = 5; // undefined low bits of byte 4
  // ------------------------------------------------------------------
  // status codes in the two top bits of the first byte
  // ------------------------------------------------------------------
  localparam logic [1:0] SDF_ST_FRESH = 2'h0; // valid new result
  localparam logic [1:0] SDF_ST_CMD   = 2'h1; // command mode
  localparam logic [1:0] SDF_ST_STALE = 2'h2; // already fetched
  localparam logic [1:0] SDF_ST_DIAG  = 2'h3; // diagnostic fault
  // ------------------------------------------------------------------
  // link timing: 20 MHz system clock, master scl half period
  // ------------------------------------------------------------------
  localparam int SDF_CLK_HZ      = 20_000_000;              // system clock rate
  localparam int SDF_SCL_HZ      = 100_000;                 // master scl rate
  localparam int SDF_SCL_HALF    = SDF_CLK_HZ / (2 * SDF_SCL_HZ); // cycles per half
  localparam int SDF_BUS_FREE_NS = 2000;                    // least stop-to-start gap
  localparam int SDF_BUS_FREE_CYC = (SDF_BUS_FREE_NS * 20 + 999) / 1000; // rounded up
  localparam int SDF_SYNC_STAGES = 2;                       // pin synchroniser depth
  // ------------------------------------------------------------------
  // diagnostic fault sources
  // ------------------------------------------------------------------
  typedef struct packed {
    logic bad_signature;  // nonvolatile signature invalid
    logic bridge_open;    // lost either bridge polarity
    logic bridge_short;   // bridge input short
    logic source_lost;    // bridge source lost
  } sdf_fault_t;
endpackage : sdf_pkg

// ### hw/sdf_link_if.sv
// interface: the two wire bus between master and sensor ends
`timescale 1ns/1ps
`default_nettype none
interface sdf_link_if;
  // ------------------------------------------------------------------
  // open-drain drive: an enable low pulls the wire low
  // ------------------------------------------------------------------
  logic scl_oe_n_m; // master scl pull enable, low pulls low
  logic sda_oe_n_m; // master sda pull enable
  logic sda_oe_n_s; // sensor sda pull enable
  logic scl;        // resolved scl level
  logic sda;        // resolved sda level
  // wired-and of all pulls with pull-up
  assign scl = scl_oe_n_m;
  assign sda = sda_oe_n_m & sda_oe_n_s;
  modport sensor (input scl, input sda, output sda_oe_n_s);
  modport master (input scl, input sda, output scl_oe_n_m, output sda_oe_n_m);
endinterface : sdf_link_if
`default_nettype wire

// ### hw/sdf_pin_sync.sv
// module: two-flop synchroniser with edge and bus-condition detection
`timescale 1ns/1ps
`default_nettype none
module sdf_pin_sync
  import sdf_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // raw pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // clean levels and events
  output logic      scl_out,
  output logic      sda_out,
  output logic      scl_rise_out,
  output logic      scl_fall_out,
  output logic      start_out,
  output logic      stop_out
);
  // ------------------------------------------------------------------
  // synchroniser stages; the first stage feeds only the second
  // ------------------------------------------------------------------
  logic [1:0] scl_sync_reg; // [0] meta, [1] clean
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;    // previous clean scl
  logic       sda_d_reg;    // previous clean sda

  // pins idle high, so reset to high avoids a false start
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else if (clk_en_in) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  // ------------------------------------------------------------------
  // edge decode on clean levels only
  // ------------------------------------------------------------------
  assign scl_out      = scl_sync_reg[1];
  assign sda_out      = sda_sync_reg[1];
  assign scl_rise_out = clk_en_in & scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall_out = clk_en_in & ~scl_sync_reg[1] & scl_d_reg;
  // sda moving while scl stays high marks start or stop
  assign start_out = clk_en_in & scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
  assign stop_out  = clk_en_in & scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
endmodule : sdf_pin_sync
`default_nettype wire

// ### hw/sdf_master.sv
// module: master end, issues data fetches of two, three or four bytes
`timescale 1ns/1ps
`default_nettype none
module sdf_master
  import sdf_pkg::*;
#(
  parameter logic [6:0] ADDR = SDF_ADDR_DEFAULT, // target address
  parameter int         HALF = SDF_SCL_HALF      // scl half period in cycles
) (
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // request
  input  wire logic        req_in,      // pulse: start a fetch
  input  wire logic [2:0]  nbytes_in,   // 2, 3 or 4
  input  wire logic        recover_in,  // send a lone extra start first
  // answer
  output logic             done_out,    // pulse: fetch finished
  output logic             nack_out,    // address not acknowledged
  output logic             busy_out,
  output logic [1:0]       status_out,
  output logic [13:0]      pressure_out,
  output logic [10:0]      temperature_out,
  // bus
  sdf_link_if.master       link
);
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP, M_FREE} sdf_mst_state_t;
  sdf_mst_state_t state_reg;
  logic [15:0] tick_reg;   // half-period counter
  logic [1:0]  phase_reg;  // step within start or stop
  logic [3:0]  bit_reg;    // bit in byte, 8 = ack slot
  logic [2:0]  byte_reg;   // 0 address, then data bytes
  logic [2:0]  nb_reg;     // bytes wanted
  logic        rec_reg;    // extra start pending
  logic [7:0]  sh_reg;     // byte in or out
  logic [31:0] rx_reg;     // collected packet
  logic        scl_reg, sda_reg, nack_reg, done_reg;
  logic        tick_w;     // half period expired
  logic        sda_in_r1, sda_in_r2; // sda synchroniser
  assign tick_w = (tick_reg == 16'(HALF - 1));
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_in_r1 <= 1'b1;
      sda_in_r2 <= 1'b1;
    end else if (clk_en_in) begin
      sda_in_r1 <= link.sda;
      sda_in_r2 <= sda_in_r1;
    end
  end
  // bit engine: each bit is scl low half then high half
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= M_IDLE; tick_reg <= 16'h0000; phase_reg <= 2'h0;
      bit_reg <= 4'h0; byte_reg <= 3'h0; nb_reg <= 3'h2; rec_reg <= 1'b0;
      sh_reg <= 8'h00; rx_reg <= 32'h0000_0000; scl_reg <= 1'b1; sda_reg <= 1'b1;
      nack_reg <= 1'b0; done_reg <= 1'b0;
    end else if (clk_en_in) begin
      done_reg <= 1'b0;
      tick_reg <= (state_reg == M_IDLE || tick_w) ? 16'h0000 : tick_reg + 16'h0001;
      unique case (state_reg)
        M_IDLE: if (req_in) begin
          state_reg <= M_START; phase_reg <= 2'h0; nack_reg <= 1'b0;
          nb_reg <= (nbytes_in < 3'h2) ? 3'h2 : (nbytes_in > 3'h4 ? 3'h4 : nbytes_in);
          rec_reg <= recover_in; // see [RL8] see [RL9]
        end
        M_START: if (tick_w) begin
          // sda falls while scl high; first address bit follows with sda held
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'h0) sda_reg <= 1'b0;
          if (phase_reg == 2'h1) begin
            scl_reg <= 1'b0; byte_reg <= 3'h0; bit_reg <= 4'h0;
            sh_reg <= {ADDR, SDF_DIR_READ}; phase_reg <= 2'h0;
            state_reg <= M_BIT; // see [RL10]
          end
        end
        M_BIT: if (tick_w) begin
          if (!scl_reg) begin
            // end of low half: place data and raise scl on the same tick
            if (rec_reg) begin
              sda_reg <= 1'b1; scl_reg <= 1'b1; // prepares a fresh start
            end else if (bit_reg == 4'h8) sda_reg <= (byte_reg == 3'h0) ? 1'b1
                                         : (byte_reg == nb_reg); // see [RL5]
            else sda_reg <= (byte_reg == 3'h0) ? sh_reg[7] : 1'b1;
            scl_reg <= 1'b1;
          end else if (rec_reg) begin
            rec_reg <= 1'b0; state_reg <= M_START; phase_reg <= 2'h0;
          end else begin
            scl_reg <= 1'b0;
            if (bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (byte_reg == 3'h0 && sda_in_r2) begin
                nack_reg <= 1'b1; state_reg <= M_STOP;
              end else if (byte_reg == nb_reg) state_reg <= M_STOP; // see [RL3]
              byte_reg <= byte_reg + 3'h1;
            end else begin
              sh_reg <= {sh_reg[6:0], sda_in_r2};
              if (byte_reg != 3'h0) rx_reg <= {rx_reg[30:0], sda_in_r2};
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        M_STOP: if (tick_w) begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == 2'h0) sda_reg <= 1'b0;
          if (phase_reg == 2'h1) scl_reg <= 1'b1;
          if (phase_reg == 2'h2) begin
            sda_reg <= 1'b1; state_reg <= M_FREE; phase_reg <= 2'h0;
          end
        end
        M_FREE: if (tick_w) begin
          state_reg <= M_IDLE; done_reg <= 1'b1;
          // align packet msb first, zero-filling bytes not read
          if (!nack_reg)
            rx_reg <= rx_reg << (6'd8 * (6'd4 - {3'h0, nb_reg})); // see [RL7]
        end
      endcase
    end
  end
  assign link.scl_oe_n_m = scl_reg;
  assign link.sda_oe_n_m = sda_reg;
  assign done_out        = done_reg;
  assign nack_out        = nack_reg;
  assign busy_out        = (state_reg != M_IDLE);
  assign status_out      = rx_reg[31:30];
  assign pressure_out    = rx_reg[29:16];
  assign temperature_out = rx_reg[15:5];
endmodule : sdf_master
`default_nettype wire

// ### test/sdf_link_asserts.sv
// checker: wire-level properties of the sensor data fetch link
`timescale 1ns/1ps
`default_nettype none
module sdf_link_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // link wires
  input wire logic scl_oe_n_m,
  input wire logic sda_oe_n_m,
  input wire logic sda_oe_n_s,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_reg, sda_reg, a0_reg, nak_reg; // delayed levels, phase flags
  logic [5:0] cnt_reg;                           // scl rises since start
  logic [7:0] sr_reg;                            // address byte as seen
  wire rise  = scl & ~scl_reg;
  wire start = scl & scl_reg & sda_reg & ~sda;
  wire slot  = cnt_reg inside {6'h11, 6'h1a, 6'h23, 6'h2c}; // next rise is master ack
  // frame phase; count saturates so idle time cannot wrap it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {scl_reg, sda_reg, a0_reg, nak_reg, cnt_reg, sr_reg} <= {2'h3, 2'h0, 6'h0, 8'h0};
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      cnt_reg <= start ? 6'h0 : cnt_reg + {5'h0, rise && cnt_reg != 6'h3f};
      sr_reg  <= (rise && cnt_reg < 6'h8) ? {sr_reg[6:0], sda} : sr_reg;
      a0_reg  <= start | (a0_reg & ~rise);
      nak_reg <= ~start & (nak_reg | (rise & slot & sda));
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rel; $fell(sys_rst_in) |-> sda_oe_n_s && sda_oe_n_m && scl_oe_n_m; endproperty
  a_rel: assert property (p_rel) else $error("bus held after reset");
  property p_early; cnt_reg < 6'h8 |-> sda_oe_n_s; endproperty
  a_early: assert property (p_early) else $error("sensor pulls in address");
  property p_own; rise && cnt_reg == 6'h8 && !sda |-> sr_reg == 8'h51; endproperty
  a_own: assert property (p_own) else $error("ack to foreign address");
  property p_stand; scl && scl_reg |-> $stable(sda_oe_n_s); endproperty
  a_stand: assert property (p_stand) else $error("sensor sda moved, scl high");
  property p_mack; scl_reg && cnt_reg inside {6'h12, 6'h1b, 6'h24, 6'h2d} |-> sda_oe_n_s;
  endproperty
  a_mack: assert property (p_mack) else $error("sensor pulls in master ack");
  property p_nak; nak_reg |-> sda_oe_n_s; endproperty
  a_nak: assert property (p_nak) else $error("sensor drives after nack");
  property p_a0; a0_reg |-> !$fell(sda); endproperty
  a_a0: assert property (p_a0) else $error("sda fell before first rise");
  property p_low; $fell(scl) |-> !scl [*8]; endproperty
  a_low: assert property (p_low) else $error("scl low too short");
endmodule : sdf_link_asserts
`default_nettype wire

// ### test/tb_sensor_i2c_data_fetch.sv
// testbench: master and sensor ends joined over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, s, e) begin n_tests++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb_sensor_i2c_data_fetch;
  import sdf_pkg::*;
  typedef struct packed {logic m; logic mid; logic [2:0] n; logic cmd; logic [1:0] st;
    logic [13:0] p; logic [10:0] t;} sdf_row_t;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, meas_done_in = 1'b0;
  logic        cmd_mode_in = 1'b0, req_in = 1'b0, recover_in = 1'b0;
  logic [13:0] pressure_in = 14'h0, pressure_out;
  logic [10:0] temperature_in = 11'h0, temperature_out;
  logic [2:0]  nbytes_in = 3'h2;
  logic [1:0]  status_out;
  sdf_fault_t  fault_in = '0;
  logic        done_out, nack_out, busy_out, diag_out, d2, nk2, nk2_reg, fet;
  int          err_count = 0, n_tests = 0, cyc = 0, nf = 0, ne = 0;
  // fresh, stale, mid-read result, its follow-up, command mode
  sdf_row_t rows [5] = '{{2'h2, 3'h2, 1'h0, 2'h0, 14'h3abc, 11'h5a3},
    {2'h0, 3'h3, 1'h0, 2'h2, 14'h3abc, 11'h5a3}, {2'h3, 3'h4, 1'h0, 2'h0, 14'h0155, 11'h2c7},
    {2'h0, 3'h2, 1'h0, 2'h0, 14'h2222, 11'h111}, {2'h2, 3'h4, 1'h1, 2'h1, 14'h1234, 11'h7ff}};
  sdf_link_if lk ();
  sdf_link_if lk2 (); // second pair: sensor at another address must stay silent
  sdf_sensor sdf_sensor_i (.clk_in, .sys_rst_in, .clk_en_in, .meas_done_in, .pressure_in,
    .temperature_in, .fault_in, .cmd_mode_in, .busy_out(), .diag_out, .fetched_out(fet), .link(lk));
  sdf_master #(.HALF(25)) sdf_master_i (.clk_in, .sys_rst_in, .clk_en_in, .req_in, .nbytes_in,
    .recover_in, .done_out, .nack_out, .busy_out, .status_out, .pressure_out, .temperature_out,
    .link(lk));
  sdf_sensor #(.ADDR(7'h29)) sdf_sensor_i2 (.clk_in, .sys_rst_in, .clk_en_in, .meas_done_in,
    .pressure_in, .temperature_in, .fault_in, .cmd_mode_in, .busy_out(), .diag_out(),
    .fetched_out(), .link(lk2));
  sdf_master #(.HALF(25)) sdf_master_i2 (.clk_in, .sys_rst_in, .clk_en_in, .req_in, .nbytes_in,
    .recover_in, .done_out(d2), .nack_out(nk2), .busy_out(), .status_out(), .pressure_out(),
    .temperature_out(), .link(lk2));
  sdf_link_asserts sdf_link_asserts_i (.clk_in, .sys_rst_in, .scl_oe_n_m(lk.scl_oe_n_m),
    .sda_oe_n_m(lk.sda_oe_n_m), .sda_oe_n_s(lk.sda_oe_n_s), .scl(lk.scl), .sda(lk.sda));
  initial forever #25 clk_in = ~clk_in;
  // latch the second pair's answer; cut a hang short
  always @(posedge clk_in) begin
    if (d2) nk2_reg <= nk2;
    if (fet) nf <= nf + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin err_count++; wrap_up(); end
  end
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic rst();
    sys_rst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'b0;
  endtask : rst
  task automatic meas(input logic [13:0] p, input logic [10:0] t);
    @(negedge clk_in);
    {meas_done_in, pressure_in, temperature_in} = {1'b1, p, t};
    @(negedge clk_in);
    meas_done_in = 1'b0;
  endtask : meas
  // one fetch; mid lands a new result while the packet is on the wire
  task automatic fetch(input logic [2:0] n, input bit mid);
    int k;
    @(negedge clk_in);
    {req_in, nbytes_in} = {1'b1, n};
    @(negedge clk_in);
    req_in = 1'b0;
    for (k = 0; k < 4000 && done_out !== 1'b1; k++) begin
      meas_done_in = mid && k == 800;
      if (meas_done_in) {pressure_in, temperature_in} = {14'h2222, 11'h111};
      @(negedge clk_in);
    end
    meas_done_in = 1'b0;
    if (k == 4000) begin err_count++; wrap_up(); end
  endtask : fetch
  task automatic check(input logic [2:0] n, input logic [1:0] st, input bit dv,
                       input logic [13:0] p, input logic [10:0] t);
    logic [10:0] m;
    m = !dv ? 11'h0 : (n == 3'h4) ? 11'h7ff : (n == 3'h3) ? 11'h7f8 : 11'h0;
    ne += n;
    `CHK("nack", nack_out, 1'b0)
    `CHK("busy", busy_out, 1'b0)
    `CHK("bytes", nf, ne)
    `CHK("status", status_out, st)
    if (dv) `CHK("pressure", pressure_out, p)
    `CHK("temp", temperature_out & m, t & m)
    `CHK("nack2", nk2_reg, 1'b1)
  endtask : check
  initial begin
    rst();
    foreach (rows[i]) begin
      cmd_mode_in = rows[i].cmd;
      if (rows[i].m) meas(rows[i].p, rows[i].t);
      fetch(rows[i].n, rows[i].mid);
      check(rows[i].n, rows[i].st, rows[i].st != 2'h1, rows[i].p, rows[i].t);
    end
    cmd_mode_in = 1'b0;
    // each fault source, gone again before the fetch: status stays latched
    for (int f = 0; f < 4; f++) begin
      rst();
      fault_in = sdf_fault_t'(4'h1 << f);
      meas(14'h0, 11'h0);
      meas(14'h0, 11'h0);
      fault_in = '0;
      meas(14'h0, 11'h0);
      fetch(3'h2, 1'b0);
      check(3'h2, 2'h3, 1'b0, 14'h0, 11'h0);
      `CHK("diag", diag_out, 1'b1)
    end
    rst();
    `CHK("diag", diag_out, 1'b0)
    recover_in = 1'b1; // lone extra start first
    fetch(3'h4, 1'b0);
    check(3'h4, 2'h2, 1'b0, 14'h0, 11'h0);
    wrap_up();
  end
endmodule : tb_sensor_i2c_data_fetch
`default_nettype wire
